// >>> core/csc_defines.svh
// Offsets, field positions, reset values and cycle counts of the clock control unit
`ifndef CSC_DEFINES_SVH
`define CSC_DEFINES_SVH

// Register byte offsets
`define CSC_FUSE_OFFSET 8'h00
`define CSC_CTRL_OFFSET 8'h04
`define CSC_STAT_OFFSET 8'h08

// Fuse register fields
`define CSC_FUSE_SRC_LSB 0
`define CSC_FUSE_SRC_MSB 3
`define CSC_FUSE_SUT_LSB 4
`define CSC_FUSE_SUT_MSB 5
`define CSC_FUSE_DIV8_BIT 6
`define CSC_FUSE_RESET 8'h22
`define CSC_FUSE_MASK 8'h7f

// Control register fields
`define CSC_CTRL_MODE_LSB 0
`define CSC_CTRL_MODE_MSB 2
`define CSC_CTRL_ENTER_BIT 3
`define CSC_CTRL_RESET 3'h0

// Oscillator start-up counts, in oscillator cycles
`define CSC_OSC_EXT_CYC 6
`define CSC_OSC_258_CYC 258
`define CSC_OSC_1K_CYC 1024
`define CSC_OSC_16K_CYC 16384
`define CSC_OSC_32K_CYC 32768

// Supply time-out counts, in watchdog oscillator cycles
`define CSC_SUPPLY_SHORT_CYC 512
`define CSC_SUPPLY_LONG_CYC 8192

// Last prescaler phase when divide-by-eight is programmed
`define CSC_DIV_LAST 3'h7

// Bus responses
`define CSC_RESP_OKAY 2'h0
`define CSC_RESP_SLVERR 2'h2

`endif

// >>> core/csc_pkg.sv
// Types shared by the clock control unit
package csc_pkg;

	// Start-up sequencer states
	typedef enum logic [2:0] {
		CSC_ST_HOLD = 3'b000,
		CSC_ST_SUPPLY = 3'b001,
		CSC_ST_OSC = 3'b010,
		CSC_ST_RUN = 3'b011,
		CSC_ST_SLEEP = 3'b100
	} csc_state_t;

	// Clock source classes
	typedef enum logic [2:0] {
		CSC_SRC_LP_XTAL = 3'b000,
		CSC_SRC_FS_XTAL = 3'b001,
		CSC_SRC_LF_XTAL = 3'b010,
		CSC_SRC_RC128 = 3'b011,
		CSC_SRC_RC_CAL = 3'b100,
		CSC_SRC_EXT = 3'b101,
		CSC_SRC_RSVD = 3'b110
	} csc_src_t;

	// Sleep modes
	typedef enum logic [2:0] {
		CSC_SLP_IDLE = 3'b000,
		CSC_SLP_CONV = 3'b001,
		CSC_SLP_PDOWN = 3'b010,
		CSC_SLP_PSAVE = 3'b011,
		CSC_SLP_STBY = 3'b110,
		CSC_SLP_XSTBY = 3'b111
	} csc_sleep_t;

endpackage

// >>> core/csc_startup_counter.sv
// Tick counter that flags when a configured number of ticks has elapsed
module csc_startup_counter #(
	parameter int W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clear,
	input wire logic tick,
	input wire logic [W-1:0] target,
	output logic done,
	output logic [W-1:0] count
);

	logic [W-1:0] count_q; // Ticks seen since the last clear
	logic [W-1:0] count_d;

	// Done once the count has reached the target
	assign done = (count_q >= target);
	assign count = count_q;
	assign count_d = clear ? '0 : ((tick && !done) ? count_q + 1'b1 : count_q);

	// Count register, cleared to zero while not in use
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end

endmodule

// >>> core/csc_top.sv
// Clock source select, start-up sequencing and clock gating with an AXI4-Lite slave
`include "csc_defines.svh"

// Functional notes
// [R1] Fuse field picks source class
// [R2] Fuse bit zero means programmed
// [R3] Factory default calibrated RC, divided, slow
// [R4] Extra supply time-out after reset release
// [R5] Supply time-out 0, 512 or 8192
// [R6] Oscillator count holds internal reset
// [R7] Sleep wake skips supply time-out
// [R8] Start-up counts from 6 to 32K
// [R9] Module clocks gate per sleep mode
// [R10] Core clock stops core state
// [R11] Async interrupt detect when I/O stopped
// [R12] Async start and address detect
// [R13] Program memory clock follows core clock
// [R14] Async timer clock runs in sleep
// [R15] Converter clock runs in noise reduction
// [R16] Configurer picks time-out over rise time
// [R17] Divide-by-eight fuse divides clock by 8
// [R18] Crystal start-up from low bit, start-up select
// [R19] Reset reassert restarts both counters
module csc_top #(
	parameter int ADDR_W = 8,
	parameter int SUPPLY_LONG_CYC = `CSC_SUPPLY_LONG_CYC,
	parameter int OSC_16K_CYC = `CSC_OSC_16K_CYC,
	parameter int OSC_32K_CYC = `CSC_OSC_32K_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic reset_sources_n,
	input wire logic wdt_tick,
	input wire logic osc_tick,
	input wire logic wake_event,
	output logic internal_reset_n,
	output logic core_clock_en,
	output logic peripheral_clock_en,
	output logic program_memory_clock_en,
	output logic async_timer_clock_en,
	output logic converter_clock_en,
	output logic async_detect_en,
	output logic system_clock_tick
);
	import csc_pkg::*;

	localparam int SW = 14; // Supply counter width
	localparam int OW = 16; // Oscillator counter width

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ---- Bus state ----
	logic [ADDR_W-1:0] awaddr_q; // Held write address
	logic aw_full_q; // Write address held
	logic aw_full_d;
	logic [7:0] wdata_q; // Held low write byte
	logic wstrb0_q; // Held lane 0 strobe
	logic w_full_q; // Write data held
	logic w_full_d;
	logic awready_q;
	logic awready_d;
	logic wready_q;
	logic wready_d;
	logic bvalid_q;
	logic bvalid_d;
	logic [1:0] bresp_q;
	logic arready_q;
	logic arready_d;
	logic rvalid_q;
	logic rvalid_d;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	// ---- Registers ----
	logic [7:0] fuse_q; // Fuse image, software written
	logic [7:0] active_cfg_q; // Fuse image captured for this sequence
	logic [2:0] ctrl_mode_q; // Requested sleep mode
	logic enter_q; // Sleep entry request pulse
	logic [2:0] active_mode_q; // Sleep mode in force
	logic [2:0] active_mode_d;
	csc_state_t state_q;
	csc_state_t state_d;
	logic [2:0] div_cnt_q; // Prescaler phase

	// ---- Gate registers ----
	logic rst_n_q;
	logic core_en_q;
	logic io_en_q;
	logic pmem_en_q;
	logic asy_en_q;
	logic conv_en_q;
	logic adet_q;
	logic tick_q;

	// ---- Write channel decode ----
	wire aw_take = s_axi_awvalid && awready_q;
	wire w_take = s_axi_wvalid && wready_q;
	wire do_write = aw_full_q && w_full_q && !bvalid_q;
	wire wr_fuse = do_write && (awaddr_q == ADDR_W'(`CSC_FUSE_OFFSET));
	wire wr_ctrl = do_write && (awaddr_q == ADDR_W'(`CSC_CTRL_OFFSET));
	wire wr_stat = do_write && (awaddr_q == ADDR_W'(`CSC_STAT_OFFSET));
	wire wr_hit = wr_fuse || wr_ctrl || wr_stat;

	assign aw_full_d = aw_take ? 1'b1 : (do_write ? 1'b0 : aw_full_q);
	assign w_full_d = w_take ? 1'b1 : (do_write ? 1'b0 : w_full_q);
	assign bvalid_d = do_write ? 1'b1 : ((bvalid_q && s_axi_bready) ? 1'b0 : bvalid_q);
	assign awready_d = !aw_full_d && !bvalid_d;
	assign wready_d = !w_full_d && !bvalid_d;

	// ---- Read channel decode ----
	wire ar_take = s_axi_arvalid && arready_q;
	wire rd_fuse = (s_axi_araddr == ADDR_W'(`CSC_FUSE_OFFSET));
	wire rd_ctrl = (s_axi_araddr == ADDR_W'(`CSC_CTRL_OFFSET));
	wire rd_stat = (s_axi_araddr == ADDR_W'(`CSC_STAT_OFFSET));
	wire rd_hit = rd_fuse || rd_ctrl || rd_stat;

	assign rvalid_d = ar_take ? 1'b1 : ((rvalid_q && s_axi_rready) ? 1'b0 : rvalid_q);
	assign arready_d = !rvalid_d;

	// ---- Active configuration fields ----
	wire [3:0] src_sel = active_cfg_q[`CSC_FUSE_SRC_MSB:`CSC_FUSE_SRC_LSB];
	wire [1:0] sut_sel = active_cfg_q[`CSC_FUSE_SUT_MSB:`CSC_FUSE_SUT_LSB];
	wire div8_on = !active_cfg_q[`CSC_FUSE_DIV8_BIT]; // Programmed reads zero, see [R2] [R17]

	// Source class from the four-bit select, see [R1]
	function automatic csc_src_t csc_decode_src(input logic [3:0] sel);
		csc_src_t cls;
		cls = CSC_SRC_RSVD;
		if (sel[3]) begin
			cls = CSC_SRC_LP_XTAL;
		end else if (sel[2:1] == 2'h3) begin
			cls = CSC_SRC_FS_XTAL;
		end else if (sel[2:1] == 2'h2) begin
			cls = CSC_SRC_LF_XTAL;
		end else if (sel == 4'h3) begin
			cls = CSC_SRC_RC128;
		end else if (sel == 4'h2) begin
			cls = CSC_SRC_RC_CAL;
		end else if (sel == 4'h0) begin
			cls = CSC_SRC_EXT;
		end
		return cls;
	endfunction

	wire csc_src_t src_class = csc_decode_src(src_sel);
	wire is_xtal = (src_class == CSC_SRC_LP_XTAL) || (src_class == CSC_SRC_FS_XTAL);
	wire [2:0] xtal_idx = {src_sel[0], sut_sel}; // Low select bit plus start-up select

	// Crystal start-up counts, see [R18]
	wire [OW-1:0] xtal_osc = (xtal_idx <= 3'h1) ? OW'(`CSC_OSC_258_CYC) :
		((xtal_idx <= 3'h4) ? OW'(`CSC_OSC_1K_CYC) : OW'(OSC_16K_CYC));
	// Crystal supply time-outs cycle 512, 8K, none
	wire [SW-1:0] xtal_sup = (xtal_idx == 3'h2 || xtal_idx == 3'h5) ? '0 :
		((xtal_idx == 3'h1 || xtal_idx == 3'h4 || xtal_idx == 3'h7) ?
		SW'(SUPPLY_LONG_CYC) : SW'(`CSC_SUPPLY_SHORT_CYC));
	// Other sources: start-up select picks none, 512 or 8K, see [R5]
	wire [SW-1:0] plain_sup = (sut_sel == 2'h0) ? '0 :
		((sut_sel == 2'h1) ? SW'(`CSC_SUPPLY_SHORT_CYC) : SW'(SUPPLY_LONG_CYC));
	// Low-frequency crystal longest, external and RC shortest, see [R8]
	wire [OW-1:0] plain_osc = (src_class == CSC_SRC_LF_XTAL) ? OW'(OSC_32K_CYC) :
		OW'(`CSC_OSC_EXT_CYC);
	wire [SW-1:0] supply_target = is_xtal ? xtal_sup : plain_sup;
	wire [OW-1:0] osc_target = is_xtal ? xtal_osc : plain_osc;

	// ---- Start-up counters ----
	logic supply_done;
	logic osc_done;
	logic [SW-1:0] supply_count;
	logic [OW-1:0] osc_count;

	// Supply time-out on watchdog ticks, see [R5] [R19]
	csc_startup_counter #(.W(SW)) u_supply (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(state_q != CSC_ST_SUPPLY),
		.tick(wdt_tick),
		.target(supply_target),
		.done(supply_done),
		.count(supply_count)
	);

	// Oscillator start-up on oscillator ticks, see [R6] [R19]
	csc_startup_counter #(.W(OW)) u_osc (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(state_q != CSC_ST_OSC),
		.tick(osc_tick),
		.target(osc_target),
		.done(osc_done),
		.count(osc_count)
	);

	// ---- Sequencer next state ----
	wire deep_sleep = (active_mode_q == CSC_SLP_PDOWN) || (active_mode_q == CSC_SLP_PSAVE);
	wire enter_now = enter_q && (state_q == CSC_ST_RUN);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			CSC_ST_HOLD: begin
				if (reset_sources_n) begin
					state_d = CSC_ST_SUPPLY; // Extra delay after release, see [R4]
				end
			end
			CSC_ST_SUPPLY: begin
				if (supply_done) begin
					state_d = CSC_ST_OSC;
				end
			end
			CSC_ST_OSC: begin
				if (osc_done) begin
					state_d = CSC_ST_RUN; // Release internal reset, see [R6]
				end
			end
			CSC_ST_RUN: begin
				if (enter_now) begin
					state_d = CSC_ST_SLEEP;
				end
			end
			CSC_ST_SLEEP: begin
				if (wake_event) begin
					// Deep sleep wakes through start-up only, see [R7]
					state_d = deep_sleep ? CSC_ST_OSC : CSC_ST_RUN;
				end
			end
			default: begin
				state_d = CSC_ST_HOLD;
			end
		endcase
		if (!reset_sources_n) begin
			state_d = CSC_ST_HOLD; // Any reset source restarts the sequence, see [R19]
		end
	end

	assign active_mode_d = enter_now ? ctrl_mode_q : active_mode_q;

	// ---- Gate decode from next state, see [R9] ----
	wire nx_run = (state_d == CSC_ST_RUN);
	wire nx_slp = (state_d == CSC_ST_SLEEP);
	wire m_idle = (active_mode_d == CSC_SLP_IDLE);
	wire m_conv = (active_mode_d == CSC_SLP_CONV);
	wire m_asy = m_idle || m_conv || (active_mode_d == CSC_SLP_PSAVE) ||
		(active_mode_d == CSC_SLP_XSTBY);
	wire core_d = nx_run; // Core state frozen otherwise, see [R10]
	wire io_d = nx_run || (nx_slp && m_idle);
	wire asy_d = nx_run || (nx_slp && m_asy); // Real-time domain, see [R14]
	wire conv_d = nx_run || (nx_slp && (m_idle || m_conv)); // See [R15]
	wire rst_n_d = nx_run || nx_slp;

	// Prescaler: one system tick per oscillator tick, or per eight, see [R17]
	wire div_wrap = !div8_on || (div_cnt_q == `CSC_DIV_LAST);

	// ---- Bus handshake registers ----
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
		end else begin
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
		end
	end

	// Bus payload capture and answers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_q <= '0;
			wdata_q <= 8'h00;
			wstrb0_q <= 1'b0;
			bresp_q <= `CSC_RESP_OKAY;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `CSC_RESP_OKAY;
		end else begin
			if (aw_take) begin
				awaddr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_q <= s_axi_wdata[7:0];
				wstrb0_q <= s_axi_wstrb[0];
			end
			if (do_write) begin
				bresp_q <= wr_hit ? `CSC_RESP_OKAY : `CSC_RESP_SLVERR;
			end
			if (ar_take) begin
				rresp_q <= rd_hit ? `CSC_RESP_OKAY : `CSC_RESP_SLVERR;
				rdata_q <= rd_fuse ? {24'h00_0000, fuse_q} :
					(rd_ctrl ? {29'h0000_0000, ctrl_mode_q} :
					(rd_stat ? {24'h00_0000, core_en_q, !rst_n_q, src_class, state_q} :
					32'h0000_0000));
			end
		end
	end

	// Software registers; fuse image defaults to the factory setting, see [R3]
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fuse_q <= `CSC_FUSE_RESET;
			ctrl_mode_q <= `CSC_CTRL_RESET;
			enter_q <= 1'b0;
		end else begin
			if (wr_fuse && wstrb0_q) begin
				fuse_q <= wdata_q & `CSC_FUSE_MASK;
			end
			if (wr_ctrl && wstrb0_q) begin
				ctrl_mode_q <= wdata_q[`CSC_CTRL_MODE_MSB:`CSC_CTRL_MODE_LSB];
			end
			enter_q <= wr_ctrl && wstrb0_q && wdata_q[`CSC_CTRL_ENTER_BIT];
		end
	end

	// Sequencer, configuration capture and prescaler
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= CSC_ST_HOLD;
			active_cfg_q <= `CSC_FUSE_RESET;
			active_mode_q <= CSC_SLP_IDLE;
			div_cnt_q <= 3'h0;
			tick_q <= 1'b0;
		end else begin
			state_q <= state_d;
			active_mode_q <= active_mode_d;
			if (state_q == CSC_ST_HOLD) begin
				active_cfg_q <= fuse_q; // Fuses take effect at each reset sequence
			end
			if (osc_tick) begin
				div_cnt_q <= div_wrap ? 3'h0 : div_cnt_q + 3'h1;
			end
			tick_q <= osc_tick && div_wrap;
		end
	end

	// Gate and reset outputs, registered from the next state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst_n_q <= 1'b0;
			core_en_q <= 1'b0;
			pmem_en_q <= 1'b0;
			io_en_q <= 1'b0;
			asy_en_q <= 1'b0;
			conv_en_q <= 1'b0;
			adet_q <= 1'b1;
		end else begin
			rst_n_q <= rst_n_d;
			core_en_q <= core_d;
			pmem_en_q <= core_d; // Follows the core clock, see [R13]
			io_en_q <= io_d;
			asy_en_q <= asy_d;
			conv_en_q <= conv_d;
			adet_q <= !io_d; // Async detectors armed when I/O stops, see [R11] [R12]
		end
	end

	// Output wiring
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign internal_reset_n = rst_n_q;
	assign core_clock_en = core_en_q;
	assign program_memory_clock_en = pmem_en_q;
	assign peripheral_clock_en = io_en_q;
	assign async_timer_clock_en = asy_en_q;
	assign converter_clock_en = conv_en_q;
	assign async_detect_en = adet_q;
	assign system_clock_tick = tick_q;

	// ---- Assertions ----
	a_src_default_rc: assert property ((src_sel == 4'h2) |-> (src_class == CSC_SRC_RC_CAL)) // see [R1]
		else $error("calibrated RC select decoded wrongly");
	a_reset_holds: assert property (!reset_sources_n |=> (state_q == CSC_ST_HOLD) ##1 !rst_n_q) // see [R4]
		else $error("internal reset not held while a reset source is active");
	a_supply_exit: assert property ((state_q == CSC_ST_SUPPLY && supply_done && reset_sources_n)
		|=> (state_q == CSC_ST_OSC)) // see [R5]
		else $error("supply time-out did not hand over to start-up count");
	a_osc_reset_low: assert property ((state_q == CSC_ST_OSC) |-> !rst_n_q) // see [R6]
		else $error("internal reset released during oscillator start-up");
	a_wake_deep: assert property ((state_q == CSC_ST_SLEEP && wake_event && reset_sources_n
		&& deep_sleep) |=> (state_q == CSC_ST_OSC) && (supply_count == '0)) // see [R7]
		else $error("deep sleep wake did not go through start-up count only");
	a_core_gate: assert property (core_en_q |-> (state_q == CSC_ST_RUN) && rst_n_q) // see [R10]
		else $error("core clock enabled outside run");
	a_flash_follow: assert property (pmem_en_q == core_en_q) // see [R13]
		else $error("program memory clock differs from core clock");
	a_div_phase: assert property ((tick_q && div8_on && $past(div8_on))
		|-> ($past(div_cnt_q) == `CSC_DIV_LAST)) // see [R17]
		else $error("divided system tick at the wrong phase");
	a_conv_quiet: assert property ((state_q == CSC_ST_SLEEP && active_mode_q == CSC_SLP_CONV)
		|-> conv_en_q && asy_en_q && !io_en_q && !core_en_q) // see [R15]
		else $error("noise reduction gating wrong");
	a_async_arm: assert property (!io_en_q |-> adet_q) // see [R11]
		else $error("async detectors not armed with I/O clock stopped");
	a_restart_zero: assert property (!reset_sources_n |=> ##1 (supply_count == '0)
		&& (osc_count == '0)) // see [R19]
		else $error("counters not restarted on reset reassert");

endmodule

// >>> verification/clock_select_startup_control_bench.sv
// Self-checking bench of the clock control unit
`include "csc_defines.svh"
module clock_select_startup_control_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import csc_pkg::*;
	// Shortened counts and tick periods
	localparam int SL = 20;
	localparam int WP = 3;
	localparam int OP = 2;
	logic aclk = 0;
	logic aresetn = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rnd;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic rst_src_n = 1, wake = 0, wdt_tick, osc_tick;
	logic irn, core, per, pm, asy, conv, adet, stick;
	int fails = 0, comparisons = 0, seed = 69, n, k, est;
	logic [33:0] rq[$];
	logic [1:0] bq[$]; // Expected write responses
	// Fuse settings with expected class, supply and oscillator counts
	logic [7:0] cf[8] = '{8'h22, 8'h40, 8'h53, 8'hf4, 8'h7f, 8'h08, 8'h66, 8'h71};
	csc_src_t cl[8] = '{CSC_SRC_RC_CAL, CSC_SRC_EXT, CSC_SRC_RC128, CSC_SRC_LF_XTAL,
		CSC_SRC_LP_XTAL, CSC_SRC_LP_XTAL, CSC_SRC_FS_XTAL, CSC_SRC_RSVD};
	int sv[8] = '{SL, 0, `CSC_SUPPLY_SHORT_CYC, SL, SL, `CSC_SUPPLY_SHORT_CYC, 0, SL};
	int ov[8] = '{6, 6, 6, 50, 40, `CSC_OSC_258_CYC, `CSC_OSC_1K_CYC, `CSC_OSC_EXT_CYC};
	// Sleep modes and expected peripheral, timer, converter gates
	logic [2:0] md[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
	logic [2:0] gt[6] = '{3'b111, 3'b011, 3'b000, 3'b010, 3'b000, 3'b010};
	always #50 aclk = ~aclk;
	csc_osc_model #(.WDT_P(WP), .OSC_P(OP)) csc_osc_model_i (
		.aclk(aclk), .wdt_tick(wdt_tick), .osc_tick(osc_tick));
	csc_top #(.SUPPLY_LONG_CYC(SL), .OSC_16K_CYC(40), .OSC_32K_CYC(50)) csc_top_i (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.reset_sources_n(rst_src_n), .wdt_tick(wdt_tick), .osc_tick(osc_tick),
		.wake_event(wake), .internal_reset_n(irn), .core_clock_en(core),
		.peripheral_clock_en(per), .program_memory_clock_en(pm),
		.async_timer_clock_en(asy), .converter_clock_en(conv),
		.async_detect_en(adet), .system_clock_tick(stick));
	// Compare and count
	task chk(input string nm, input logic [33:0] s, input logic [33:0] e);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", nm, e, s);
		end
	endtask
	// Write cycle, address and data offered together
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		bq.push_back(e);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end while (awvalid || wvalid);
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask
	// Read cycle, expectation queued for the monitor
	task rd(input logic [7:0] a, input logic [33:0] e);
		rq.push_back(e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end while (arvalid);
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask
	// Response monitor takes the oldest note of each queue
	always @(posedge aclk) begin
		if (rvalid === 1'b1 && rready === 1'b1) begin
			chk("read", {rresp, rdata}, rq.pop_front());
		end
		if (bvalid === 1'b1 && bready === 1'b1) begin
			chk("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
		end
	end
	// Pulse of the other reset sources
	task pulse();
		@(posedge aclk);
		rst_src_n <= 1'b0;
		repeat (2) @(posedge aclk);
		rst_src_n <= 1'b1;
	endtask
	task summarize();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Watchdog against hangs
	initial begin
		#(100 * 40000);
		fails++;
		summarize();
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`CSC_FUSE_OFFSET, 34'h22);
		// Every source class and start-up selection
		for (int i = 0; i < 8; i++) begin
			rnd = $random(seed);
			wr(`CSC_FUSE_OFFSET, {rnd[31:8], cf[i]}, `CSC_RESP_OKAY);
			if (i == 0) begin
				pulse();
				repeat (20) @(posedge aclk);
			end
			pulse();
			n = 0;
			while (irn !== 1'b1) begin
				@(posedge aclk);
				n++;
			end
			est = sv[i] * WP + ov[i] * OP;
			chk("startup", n >= est - 4 && n <= est + 12, 1);
			rd(`CSC_STAT_OFFSET, {2'h0, 24'h00_0000, 2'b10, cl[i], 3'h3});
			rd(`CSC_FUSE_OFFSET, {26'h0, cf[i] & `CSC_FUSE_MASK});
			k = 0;
			repeat (64) begin
				@(posedge aclk);
				if (stick === 1'b1) k++;
			end
			chk("divide", k, cf[i][6] ? 32 : 4);
		end
		// Sleep gating and wake paths
		for (int j = 0; j < 6; j++) begin
			rnd = $random(seed);
			wr(`CSC_CTRL_OFFSET, {rnd[31:4], 1'b1, md[j]}, `CSC_RESP_OKAY);
			repeat (4) @(posedge aclk);
			chk("gates", {28'h0, core, pm, per, asy, conv, adet},
				{28'h0, 2'b0, gt[j], ~gt[j][2]});
			@(posedge aclk);
			wake <= 1'b1;
			@(posedge aclk);
			wake <= 1'b0;
			n = 0;
			while (core !== 1'b1) begin
				@(posedge aclk);
				n++;
			end
			est = (md[j] == 3'h2 || md[j] == 3'h3) ? 6 * OP : 0;
			chk("wake", n >= est - 4 && n <= est + 12, 1);
			chk("run gates", {31'h0, core, pm, irn}, {31'h0, 3'b111});
			rd(`CSC_CTRL_OFFSET, {31'h0, md[j]});
		end
		// Unmapped place and read-only status
		rd(8'h0c, {`CSC_RESP_SLVERR, 32'h0});
		wr(8'h0c, rnd, `CSC_RESP_SLVERR);
		wr(`CSC_STAT_OFFSET, rnd, `CSC_RESP_OKAY);
		rd(`CSC_STAT_OFFSET, {2'h0, 24'h00_0000, 2'b10, CSC_SRC_RSVD, 3'h3});
		summarize();
	end
endmodule

// >>> verification/csc_osc_model.sv
// Behavioural watchdog and selected oscillator tick sources
module csc_osc_model #(
	parameter int WDT_P = 3,
	parameter int OSC_P = 2
) (
	input wire logic aclk,
	output logic wdt_tick,
	output logic osc_tick
);
	timeunit 1ns;
	timeprecision 1ns;
	// Phase counters of the two oscillators
	int wdt_q = 0;
	int osc_q = 0;
	// Ticks are unknown only before the first edge, well inside the bench's reset
	// Oscillators run free, independent of any reset
	always @(posedge aclk) begin
		wdt_q <= (wdt_q + 1) % WDT_P;
		osc_q <= (osc_q + 1) % OSC_P;
		wdt_tick <= (wdt_q == 0);
		osc_tick <= (osc_q == 0);
	end
endmodule
